/* File: rtl/wdk_top.sv */
// Watchdog timer, halt/idle control and wake-up logic with a Wishbone slave.
// Assumes the CPU pulses halt and clear-watchdog for one clk_i cycle each, and
// that a reset generator outside acts on the reset pulses driven here.
//
// Function
// - Halt with fast idle 1, slow idle 0 keeps fast clock, stops sub clock, stalls CPU.
// - While halted, memory, registers and ports are held unchanged.
// - Halt sets power-down flag and clears timeout flag.
// - Halt clears the watchdog count; counting continues only when enabled.
// - Halted device wakes on reset pin, Port A fall, interrupt or watchdog overflow.
// - Reset pin wake gives full reset; overflow wake resets only PC and SP.
// - Power-down flag cleared by power-up or clear instruction, set by halt.
// - Per-pin Port A wake enables; falling edge resumes after halt.
// - Disabled or stack-full waking interrupt resumes after halt, stays pending.
// - Enabled waking interrupt with stack room gets normal interrupt service.
// - Interrupt already requesting before halt cannot wake the device.
// - Watchdog counts slow RC clock; select picks divider 2^8 to 2^18.
// - Key 10101B disables watchdog, 01010B enables it.
// - Any other key resets device after fixed delay, sets watchdog soft-reset flag.
// - Key field holds 01010B after power-on.
// - Watchdog soft-reset flag set by hardware, software may only clear it.
// - Timeout while running resets device and sets timeout flag.
// - Timeout while halted sets timeout and power-down, resets only PC and SP.
// - Count cleared by bad key, clear instruction, halt, or selected reset pin low.
// - Upper four bits of reset flag register read zero.
// - Reset-control flag set by bad reset-control value, cleared only by software.
//
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ns

module wdk_top #(
    parameter int SOFT_RESET_DELAY = wdk_pkg::WDK_SRST_DLY_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        low_speed_internal_rc_clk_i,
    input  wire logic        halt_i,
    input  wire logic        clear_wdt_i,
    input  wire logic [7:0]  port_a_i,
    input  wire logic [7:0]  irq_req_i,
    input  wire logic [7:0]  irq_en_i,
    input  wire logic        stack_full_i,
    input  wire logic        ext_reset_n_i,
    input  wire logic        reset_pin_sel_i,
    input  wire logic        reset_pin_control_invalid_i,
    input  wire logic        lvr_event_i,
    input  wire logic        lvrc_invalid_i,
    output logic             cpu_stall_o,
    output logic             state_hold_o,
    output logic             fast_clk_en_o,
    output logic             sub_clk_en_o,
    output logic             sys_reset_o,
    output logic             wdt_reset_o,
    output logic             pc_sp_reset_o,
    output logic             resume_o,
    output logic      [7:0]  irq_service_o,
    output logic             power_down_flag_o,
    output logic             timeout_flag_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers: slow RC clock, reset pin and Port A are asynchronous
    localparam int SW = wdk_pkg::WDK_NUM_PA + 2;

    logic [SW-1:0] meta_q;
    logic [SW-1:0] sync_q;
    logic [SW-1:0] prev_q;

    // Two flops before any logic reads the pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= {SW{1'b1}};
            sync_q <= {SW{1'b1}};
        end else begin
            meta_q <= {low_speed_internal_rc_clk_i, ext_reset_n_i, port_a_i};
            sync_q <= meta_q;
        end
    end

    // Reset high so no false Port A fall follows reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= {SW{1'b1}};
        end else begin
            prev_q <= sync_q;
        end
    end

    // Slow clock sampled as data: each half period needs three clk_i cycles
    wire       low_speed_internal_rc_tick = sync_q[SW-1] & ~prev_q[SW-1];
    wire       res_low   = reset_pin_sel_i & ~sync_q[SW-2];
    wire [7:0] pa_fall   = prev_q[7:0] & ~sync_q[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    wdk_pkg::wdk_state_e state_q;
    wdk_pkg::wdk_state_e state_d;

    logic [7:0]  wdc_q;
    logic [7:0]  wdc_d;
    logic [3:0]  rsf_q;
    logic [3:0]  rsf_d;
    logic [1:0]  pwr_q;
    logic [7:0]  paw_q;
    logic        pdf_q;
    logic        pdf_d;
    logic        to_q;
    logic        to_d;
    logic [1:0]  mode_q;
    logic [7:0]  armed_q;
    logic [wdk_pkg::WDK_CNT_W-1:0] cnt_q;
    logic [wdk_pkg::WDK_CNT_W-1:0] cnt_d;
    logic [15:0] srst_q;
    logic        ack_q;
    logic [7:0]  rdat_q;
    logic        sys_rst_q;
    logic        wdt_rst_q;
    logic        pcsp_q;
    logic        resume_q;
    logic [7:0]  svc_q;

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone decode: ack one cycle after request, write at the ack edge
    // Classic single cycle only, no bursts
    wire req    = wb_cyc_i & wb_stb_i;
    wire wr_go  = req & wb_we_i & ack_q & wb_sel_i[0];
    wire wr_wdc = wr_go & (wb_adr_i == wdk_pkg::WDK_ADR_WDC);
    wire wr_rsf = wr_go & (wb_adr_i == wdk_pkg::WDK_ADR_RSF);
    wire wr_pwr = wr_go & (wb_adr_i == wdk_pkg::WDK_ADR_PWR);
    wire wr_paw = wr_go & (wb_adr_i == wdk_pkg::WDK_ADR_PAW);

    wire [7:0] sts_rd = {6'h00, to_q, pdf_q};
    // Unmapped addresses read zero and ignore writes
    wire [7:0] rd_data =
        (wb_adr_i == wdk_pkg::WDK_ADR_WDC) ? wdc_q :
        (wb_adr_i == wdk_pkg::WDK_ADR_RSF) ? {4'h0, rsf_q} :
        (wb_adr_i == wdk_pkg::WDK_ADR_PWR) ? {6'h00, pwr_q} :
        (wb_adr_i == wdk_pkg::WDK_ADR_STS) ? sts_rd :
        (wb_adr_i == wdk_pkg::WDK_ADR_PAW) ? paw_q : 8'h00;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Read data is caught at the request edge and stands during ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= 8'h00;
        end else if (req & ~ack_q) begin
            rdat_q <= rd_data;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = {24'h000000, rdat_q};

    ////////////////////////////////////////////////////////////////////////////
    // Key field and soft reset delay
    wire [4:0] key     = wdc_q[wdk_pkg::WDK_KEY_MSB:wdk_pkg::WDK_KEY_LSB];
    wire [4:0] wr_key  = wb_dat_i[wdk_pkg::WDK_KEY_MSB:wdk_pkg::WDK_KEY_LSB];
    wire       wdt_en  = (key == wdk_pkg::WDK_KEY_ON);
    wire       key_bad = (key != wdk_pkg::WDK_KEY_ON) & (key != wdk_pkg::WDK_KEY_OFF);
    wire       bad_wr  = wr_wdc & (wr_key != wdk_pkg::WDK_KEY_ON) &
                         (wr_key != wdk_pkg::WDK_KEY_OFF);
    // Noise on the held key counts the same as a bad write
    wire       srst_fire = key_bad & (srst_q == 16'(SOFT_RESET_DELAY - 1));

    // Delay counter runs only while the held key is bad
    always_ff @(posedge clk_i) begin
        if (rst_i | ~key_bad) begin
            srst_q <= 16'h0000;
        end else begin
            srst_q <= srst_q + 16'h0001;
        end
    end

    // Reloading the power-on key stops repeated soft resets
    assign wdc_d = srst_fire ? wdk_pkg::WDK_WDC_RST :
                   wr_wdc    ? wb_dat_i[7:0] : wdc_q;

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog counter
    wire       running = (state_q == wdk_pkg::WDK_RUN);
    wire       halted  = (state_q == wdk_pkg::WDK_HALT);
    wire       halt_go = halt_i & running;
    wire [4:0] to_exp  = wdk_pkg::WDK_TO_EXP[wdc_q[wdk_pkg::WDK_SEL_MSB:0]];
    // Terminal count 2^N-1, so overflow lands on the 2^N-th tick
    wire [wdk_pkg::WDK_CNT_W-1:0] term =
        wdk_pkg::WDK_CNT_ONES >> (wdk_pkg::WDK_CNT_TOP - to_exp);
    wire       ovf     = wdt_en & low_speed_internal_rc_tick & (cnt_q == term);
    wire       cnt_clr = bad_wr | clear_wdt_i | halt_go | res_low;

    // Disabled watchdog stays cleared and stopped
    assign cnt_d = (cnt_clr | ovf | ~wdt_en) ? '0 :
                   low_speed_internal_rc_tick ? cnt_q + 18'h00001 : cnt_q;

    ////////////////////////////////////////////////////////////////////////////
    // Status flags: hardware set wins over a clear in the same cycle
    assign pdf_d = (halt_go | (halted & ovf)) | (pdf_q & ~clear_wdt_i);
    assign to_d  = ovf | (to_q & ~(halt_go | clear_wdt_i));

    // Flags accept write-zero only; writing one leaves them alone
    wire [3:0] rsf_set = {reset_pin_control_invalid_i, lvr_event_i, lvrc_invalid_i, srst_fire};
    wire [3:0] rsf_clr = {4{wr_rsf}} & ~wb_dat_i[3:0];
    assign rsf_d = (rsf_q & ~rsf_clr) | rsf_set;

    ////////////////////////////////////////////////////////////////////////////
    // Wake-up sources
    wire [7:0] pa_wake  = pa_fall & paw_q;
    wire [7:0] irq_wake = irq_req_i & armed_q;
    wire [7:0] irq_ok   = irq_wake & irq_en_i & {8{~stack_full_i}};
    wire       pa_any   = |pa_wake;
    wire       irq_any  = |irq_wake;
    // A reset source in the same cycle outranks a soft wake
    wire       soft_wake = halted & ~res_low & ~ovf & (pa_any | irq_any);
    wire       wake     = halted & (res_low | ovf | pa_any | irq_any);

    // Halt is ignored while already halted
    always_comb begin
        state_d = state_q;
        case (state_q)
            wdk_pkg::WDK_RUN: begin
                if (halt_go) begin
                    state_d = wdk_pkg::WDK_HALT;
                end
            end
            wdk_pkg::WDK_HALT: begin
                if (wake) begin
                    state_d = wdk_pkg::WDK_RUN;
                end
            end
            default: begin
                state_d = wdk_pkg::WDK_RUN;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State and register update
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= wdk_pkg::WDK_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // Soft reset reloads the key; other writes follow software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdc_q <= wdk_pkg::WDK_WDC_RST;
        end else begin
            wdc_q <= wdc_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rsf_q <= wdk_pkg::WDK_RSF_RST;
        end else begin
            rsf_q <= rsf_d;
        end
    end

    // Flags start clear: only power-up reaches rst_i
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pdf_q <= 1'b0;
        end else begin
            pdf_q <= pdf_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            to_q <= 1'b0;
        end else begin
            to_q <= to_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_q <= wdk_pkg::WDK_PWR_RST;
        end else if (wr_pwr) begin
            pwr_q <= wb_dat_i[1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            paw_q <= wdk_pkg::WDK_PAW_RST;
        end else if (wr_paw) begin
            paw_q <= wb_dat_i[7:0];
        end
    end

    // Mode and wake mask freeze at halt, so writes while halted
    // cannot change the clocks in use
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q  <= 2'b00;
            armed_q <= 8'h00;
        end else if (halt_go) begin
            mode_q  <= pwr_q;
            armed_q <= ~irq_req_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset and wake pulses
    // Registered so the reset generator never sees a decode glitch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_rst_q <= 1'b0;
        end else begin
            sys_rst_q <= res_low | srst_fire;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_rst_q <= 1'b0;
            pcsp_q    <= 1'b0;
        end else begin
            wdt_rst_q <= ovf & running;
            pcsp_q    <= ovf & halted;
        end
    end

    // Pending request is left for the interrupt logic to serve later
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            resume_q <= 1'b0;
            svc_q    <= 8'h00;
        end else begin
            resume_q <= soft_wake & (pa_any | (irq_ok == 8'h00));
            svc_q    <= soft_wake ? irq_ok : 8'h00;
        end
    end

    assign sys_reset_o   = sys_rst_q;
    assign wdt_reset_o   = wdt_rst_q;
    assign pc_sp_reset_o = pcsp_q;
    assign resume_o      = resume_q;
    assign irq_service_o = svc_q;

    ////////////////////////////////////////////////////////////////////////////
    // Clock enables follow the mode latched at halt; stall and hold follow the halt state
    // Enables drop only in the halt state, never on a bus write
    assign cpu_stall_o   = halted;
    assign state_hold_o  = halted;
    assign fast_clk_en_o = running | mode_q[wdk_pkg::WDK_PWR_FHID];
    assign sub_clk_en_o  = running | mode_q[wdk_pkg::WDK_PWR_FSID];

    // Flags leave as registered levels
    assign power_down_flag_o = pdf_q;
    assign timeout_flag_o    = to_q;

endmodule

/* File: rtl/wdk_pkg.sv */
// Constants for the watchdog and wake-up controller.
// Assumes a 32-bit classic Wishbone bus and an 8-bit register file in the low lane.
package wdk_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [7:0] WDK_ADR_WDC = 8'h00;
    localparam logic [7:0] WDK_ADR_RSF = 8'h04;
    localparam logic [7:0] WDK_ADR_PWR = 8'h08;
    localparam logic [7:0] WDK_ADR_STS = 8'h0c;
    localparam logic [7:0] WDK_ADR_PAW = 8'h10;

    ////////////////////////////////////////////////////////////////////////////
    // watchdog_control layout
    localparam logic [7:0] WDK_WDC_RST = 8'h53;
    localparam int         WDK_KEY_LSB = 3;
    localparam int         WDK_KEY_MSB = 7;
    localparam int         WDK_SEL_MSB = 2;
    localparam logic [4:0] WDK_KEY_OFF = 5'h15;
    localparam logic [4:0] WDK_KEY_ON  = 5'h0a;

    // reset_source_flags layout
    localparam int         WDK_RSF_WRF  = 0;
    localparam int         WDK_RSF_LRF  = 1;
    localparam int         WDK_RSF_LOW_VOLTAGE_RESET_FLAG = 2;
    localparam int         WDK_RSF_RESETCTL_SOFT_RESET_FLAG = 3;
    localparam logic [3:0] WDK_RSF_RST  = 4'h0;

    // system_clock_control idle bits and status bits
    localparam int         WDK_PWR_FHID = 0;
    localparam int         WDK_PWR_FSID = 1;
    localparam logic [1:0] WDK_PWR_RST  = 2'h0;
    localparam int         WDK_STS_PDF  = 0;
    localparam int         WDK_STS_TO   = 1;
    localparam logic [7:0] WDK_PAW_RST  = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Sizes and timing
    localparam int WDK_NUM_PA  = 8;
    localparam int WDK_NUM_IRQ = 8;
    localparam int WDK_CNT_W   = 18;
    localparam logic [WDK_CNT_W-1:0] WDK_CNT_ONES = 18'h3ffff;
    localparam logic [4:0] WDK_CNT_TOP = 5'h12;
    // Divider exponent per timeout_select code 0..7
    localparam logic [7:0][4:0] WDK_TO_EXP = {5'h12, 5'h11, 5'h10, 5'h0f,
                                              5'h0e, 5'h0c, 5'h0a, 5'h08};
    localparam int WDK_SRST_DLY_CYC = 32;

    typedef enum logic [1:0] {
        WDK_RUN  = 2'b01,
        WDK_HALT = 2'b10
    } wdk_state_e;

endpackage

/* File: testbench/wdk_props.sv */
// Port-level checks for wdk_top: bus handshake, halt entry, wake-up pulses.
// Assumes one clk_i domain and synchronous active-high rst_i.
`timescale 1ns/1ns
module wdk_props (
    input logic        clk_i,
    input logic        rst_i,
    input logic        wb_cyc_i,
    input logic        wb_stb_i,
    input logic        wb_we_i,
    input logic [7:0]  wb_adr_i,
    input logic [31:0] wb_dat_o,
    input logic        wb_ack_o,
    input logic        halt_i,
    input logic        clear_wdt_i,
    input logic        cpu_stall_o,
    input logic        state_hold_o,
    input logic        wdt_reset_o,
    input logic        pc_sp_reset_o,
    input logic        resume_o,
    input logic [7:0]  irq_service_o,
    input logic        power_down_flag_o,
    input logic        timeout_flag_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    AST_HALT_ENTRY: assert property (halt_i && !cpu_stall_o |=>
        cpu_stall_o && power_down_flag_o && !timeout_flag_o) else $error("halt entry");
    AST_HOLD: assert property (cpu_stall_o |-> state_hold_o)
        else $error("state not held");
    AST_RUN_TIMEOUT: assert property (wdt_reset_o |-> ##[0:1] timeout_flag_o)
        else $error("timeout flag missing");
    AST_IDLE_TIMEOUT: assert property (pc_sp_reset_o |-> !cpu_stall_o ##[0:1]
        (timeout_flag_o && power_down_flag_o)) else $error("idle timeout");
    AST_RESUME: assert property (resume_o |-> !cpu_stall_o && irq_service_o == 8'h00)
        else $error("resume");
    AST_CLR_PDF: assert property (clear_wdt_i && !halt_i && !cpu_stall_o |=>
        !power_down_flag_o) else $error("pdf kept");
    AST_RSF_UPPER: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h04 |->
        wb_dat_o[31:4] == 28'h0) else $error("upper bits");
endmodule
bind wdk_top wdk_props i_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .halt_i(halt_i), .clear_wdt_i(clear_wdt_i), .cpu_stall_o(cpu_stall_o),
    .state_hold_o(state_hold_o), .wdt_reset_o(wdt_reset_o), .pc_sp_reset_o(pc_sp_reset_o),
    .resume_o(resume_o), .irq_service_o(irq_service_o), .power_down_flag_o(power_down_flag_o),
    .timeout_flag_o(timeout_flag_o));

/* File: testbench/tb_wdk_top.sv */
// Self-checking bench for wdk_top: registers, watchdog, halt and wake-up.
// Assumes the design compiles first; the slow RC clock is made here.
`timescale 1ns/1ns
module tb_wdk_top;
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0]  sel = 4'h0;
    logic [7:0]  adr = 8'h00, pa = 8'hff, ireq = 8'h00, ien = 8'h00, svc;
    logic [31:0] wdat = 32'h0, rdat;
    logic        ack, halt = 1'b0, clr = 1'b0, sfull = 1'b0, rst_n = 1'b1, psel = 1'b0;
    logic        rinv = 1'b0, run = 1'b0, stall, hold, fen, sen, srst, wrst, pcsp, res, power_down_flag, tof;
    logic [2:0]  lph = 3'h0;
    int          edges = 0, fails = 0, samples_checked = 0;
    wire  [4:0]  ev = {|svc, res, pcsp, wrst, srst};
    always #5 clk = ~clk;
    // RC clock stands low while stopped, so no edge is lost between counts
    always @(posedge clk) begin
        lph <= run ? lph + 3'h1 : 3'h0;
        if (run && lph == 3'h3) edges <= edges + 1;
    end
    wdk_top #(.SOFT_RESET_DELAY(4)) i_wdk_top (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .low_speed_internal_rc_clk_i(lph[2]), .halt_i(halt), .clear_wdt_i(clr),
        .port_a_i(pa), .irq_req_i(ireq), .irq_en_i(ien), .stack_full_i(sfull),
        .ext_reset_n_i(rst_n), .reset_pin_sel_i(psel), .reset_pin_control_invalid_i(rinv), .lvr_event_i(1'b0),
        .lvrc_invalid_i(1'b0), .cpu_stall_o(stall), .state_hold_o(hold), .fast_clk_en_o(fen),
        .sub_clk_en_o(sen), .sys_reset_o(srst), .wdt_reset_o(wrst), .pc_sp_reset_o(pcsp),
        .resume_o(res), .irq_service_o(svc), .power_down_flag_o(power_down_flag), .timeout_flag_o(tof));
    ////////////////////////////////////////////////////////////
    task automatic stop_test;
        if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h1;
        adr <= a;
        wdat <= {24'h0, d};
        do begin
            tk(1);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        tk(1);
        chk("ack drop", ack, 1'b0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(n, q, {24'h0, e});
    endtask
    task automatic pulse(input bit h);
        if (h) halt <= 1'b1;
        else clr <= 1'b1;
        tk(1);
        halt <= 1'b0;
        clr <= 1'b0;
        tk(2);
    endtask
    task automatic wev(input int b, input int lim, output int t);
        t = 0;
        while (ev[b] !== 1'b1 && t < lim) begin
            tk(1);
            t++;
        end
    endtask
    task automatic count(input int b, output int n);
        int e0, t;
        e0 = edges;
        run <= 1'b1;
        wev(b, 12000, t);
        n = edges - e0;
        run <= 1'b0;
        tk(2);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_wdt;
        int n;
        rd("wdc", 8'h00, 8'h53);
        rd("rsf", 8'h04, 8'h00);
        wr(8'h0c, 8'hff);
        rd("sts", 8'h0c, 8'h00);
        rd("unmapped", 8'h14, 8'h00);
        for (int s = 0; s < 2; s++) begin
            wr(8'h00, 8'h50 | 8'(s));
            pulse(1'b0);
            count(1, n);
            chk("edges", n, 256 << (2 * s));
            rd("sts", 8'h0c, 8'h02);
        end
        pulse(1'b0);
        rd("sts", 8'h0c, 8'h00);
        wr(8'h00, 8'ha8);
        count(1, n);
        chk("disabled", n > 300, 1);
        wr(8'h00, 8'h50);
    endtask
    task automatic t_halt;
        int t;
        wr(8'h08, 8'h01);
        wr(8'h10, 8'h04);
        pulse(1'b1);
        chk("idle", {stall, hold, fen, sen}, 4'he);
        rd("sts", 8'h0c, 8'h01);
        pa <= 8'hf7;
        wev(3, 20, t);
        chk("masked pin", t, 20);
        pa <= 8'hf3;
        wev(3, 20, t);
        chk("pin wake", t < 20, 1);
        pa <= 8'hff;
        for (int k = 0; k < 3; k++) begin
            ien <= (k > 0) ? 8'h02 : 8'h00;
            sfull <= (k == 2);
            pulse(1'b1);
            ireq <= 8'h02;
            wev((k == 1) ? 4 : 3, 20, t);
            chk("irq wake", t < 20, 1);
            chk("svc", svc, (k == 1) ? 8'h02 : 8'h00);
            ireq <= 8'h00;
            tk(2);
        end
        wr(8'h08, 8'h02);
        ireq <= 8'h10;
        pulse(1'b1);
        ireq <= 8'h00;
        tk(2);
        ireq <= 8'h10;
        wev(3, 20, t);
        chk("stale irq", stall, 1);
        chk("slow idle", {fen, sen}, 2'h1);
        pa <= 8'hfb;
        wev(3, 20, t);
        pa <= 8'hff;
        pulse(1'b1);
        count(2, t);
        chk("idle edges", t, 256);
        rd("sts", 8'h0c, 8'h03);
        pulse(1'b0);
        rd("sts", 8'h0c, 8'h00);
    endtask
    task automatic t_reset;
        int t;
        wr(8'h00, 8'h00);
        wev(0, 40, t);
        chk("key reset", t < 40, 1);
        tk(1);
        rd("rsf", 8'h04, 8'h01);
        rd("wdc", 8'h00, 8'h53);
        wr(8'h04, 8'hff);
        rd("rsf", 8'h04, 8'h01);
        wr(8'h04, 8'h00);
        wr(8'h04, 8'hff);
        rd("rsf", 8'h04, 8'h00);
        rinv <= 1'b1;
        tk(1);
        rinv <= 1'b0;
        tk(1);
        rd("rsf", 8'h04, 8'h08);
        psel <= 1'b1;
        pulse(1'b1);
        rst_n <= 1'b0;
        wev(0, 20, t);
        chk("pin reset", t < 20, 1);
        rst_n <= 1'b1;
        tk(5);
        chk("awake", stall, 0);
    endtask
    initial begin
        tk(8);
        rst <= 1'b0;
        tk(1);
        t_wdt();
        t_halt();
        t_reset();
        stop_test();
    end
    initial begin
        #400000;
        fails++;
        stop_test();
    end
endmodule
